// [sdb_regs.svh]
// Constants of the delta-sigma bitstream port: timing counts and coding.
// Assumes the system clock mclk runs at 100 MHz.
`ifndef SDB_REGS_SVH
`define SDB_REGS_SVH

// System clock
`define SDB_MCLK_PERIOD_NS  10
`define SDB_MCLK_FREQ_KHZ   100000

// Modulator clock and stream
`define SDB_MOD_CLK_KHZ     2048
`define SDB_MOD_HALF_CYCLES (`SDB_MCLK_FREQ_KHZ / (2 * `SDB_MOD_CLK_KHZ))
`define SDB_MOD_PER_BIT     4
`define SDB_BIT_RATE_KBPS   512
`define SDB_BIT_PERIOD_NS   1953

// Power-down after clock loss
`define SDB_PD_TIME_NS      40000
`define SDB_PD_CYCLES       ((`SDB_PD_TIME_NS + `SDB_MCLK_PERIOD_NS - 1) / `SDB_MCLK_PERIOD_NS)

// Recovery from instability, in modulator clock cycles
`define SDB_RECOVER_MODCLKS 32

// Input coding: full scale of the signed 24-bit level, over-range at 5 %
`define SDB_FULL_SCALE      32'sh0040_0000
`define SDB_OVER_RANGE      32'sh0043_3333
// Idle-tone offset, -60 mV of 2.5 V full scale
`define SDB_IDLE_OFFSET     32'sh0001_8937
// Loop feedback level; input gain 23/8 gives 86 % / 14 % at full scale
`define SDB_FEEDBACK        32'sh0100_0000
`define SDB_GAIN_NUM        32'sh0000_0017
`define SDB_GAIN_SHIFT      3

// Decimation: window of stream bits and code gain per net one
`define SDB_DECIM_BITS      4096
`define SDB_DECIM_GAIN      2068

`endif

// [sdb_pkg.sv]
// Types shared by both ends of the bitstream port.
// Assumes sdb_regs.svh for the numeric constants.
package sdb_pkg;

  typedef enum logic [1:0] {
    SDB_ST_DOWN  = 2'b00,
    SDB_ST_ARMED = 2'b01,
    SDB_ST_RUN   = 2'b11
  } sdb_state_t;

  typedef struct packed {
    logic               clk_s1;
    logic               clk_s2;
    logic               clk_s3;
    logic               sync_s1;
    logic               sync_s2;
    logic               sync_cap;
    logic               sync_prev;
    sdb_state_t         state;
    logic [11:0]        idle_cnt;
    logic [1:0]         phase;
    logic signed [31:0] int1;
    logic signed [31:0] int2;
    logic               unstable;
    logic [5:0]         ok_cnt;
    logic               stream_bit;
    logic               flag;
    logic               instant;
  } sdb_mod_state_t;

  typedef struct packed {
    logic [7:0]         div_cnt;
    logic               mod_clk;
    logic               sync_pend;
    logic               sync_out;
    logic               aligned;
    logic [1:0]         phase;
    logic               bit_s1;
    logic               bit_s2;
    logic               flag_s1;
    logic               flag_s2;
    logic [12:0]        ones;
    logic [12:0]        bits;
    logic [12:0]        ones_count;
    logic signed [23:0] raw;
    logic signed [23:0] offset;
    logic signed [23:0] result;
    logic               result_valid;
  } sdb_filt_state_t;

endpackage

// [sdb_link_if.sv]
// Link between the modulator and its decimating filter.
// Assumes both ends run on the same mclk; the filter makes the modulator clock.
interface sdb_link_if;
  logic mod_clk;
  logic sync;
  logic stream_bit;
  logic overrange_error_flag;

  modport modulator (
    input  mod_clk,
    input  sync,
    output stream_bit,
    output overrange_error_flag
  );

  modport filter (
    output mod_clk,
    output sync,
    input  stream_bit,
    input  overrange_error_flag
  );
endinterface

// [sdb_modulator.sv]
// Modulator end: samples the link clock and sync, emits the one-bit stream.
// Assumes mod_clk and sync come from another chip and are synchronised here.
`include "sdb_regs.svh"

// Contract
// - Filter supplies clock, sync; takes stream, flag
// - Clock stopped means automatic power-down
// - Power-down completes 40 us after clock stops
// - Sync valid around, captured on, falling edge
// - Next rising edge is the sync instant
// - Stream rate 512 kbit/s at nominal clock
// - Each bit held one 1953 ns period
// - Ones density tracks input linearly
// - Density is ones over total bits
// - Density 50 %, 86 %, 14 % at scale points
// - Filter decimates stream to 24-bit words
// - Corrected codes A2EBE0, 000000, 5D1420
// - Uncorrected -60 mV codes 5AD840/FDC420/A527C0
// - Uncorrected -35 mV codes 5BC688/FEB268/A43978
// - Filter makes modulator clock near 2.048 MHz
// - Sync rising edge restarts conversion sequencing
// - Instability: first-order fallback, flag rises
// - Recover after 32 in-range clock cycles
module sdb_modulator #(
  parameter int          PD_CYCLES = `SDB_PD_CYCLES,
  parameter int          RECOVER   = `SDB_RECOVER_MODCLKS
) (
  input  wire logic               mclk,
  input  wire logic               reset,
  sdb_link_if.modulator           link,
  input  wire logic signed [23:0] analog_level,
  input  wire logic               idle_tone_offset_enable,
  output logic                    powered_down,
  output logic                    sync_instant
);

  sdb_pkg::sdb_mod_state_t q;
  sdb_pkg::sdb_mod_state_t next_q;

  // Scaled loop input from the signed level
  function automatic logic signed [31:0] loop_input(input logic signed [31:0] lvl);
    logic signed [31:0] prod;
    prod = lvl * `SDB_GAIN_NUM;
    return prod >>> `SDB_GAIN_SHIFT;
  endfunction

  // Magnitude of a signed word
  function automatic logic signed [31:0] magnitude(input logic signed [31:0] v);
    return (v < 0) ? -v : v;
  endfunction

  logic               clk_rise;
  logic               clk_fall;
  logic               clk_edge;
  logic               sync_rise;
  logic signed [31:0] level;
  logic signed [31:0] u;
  logic signed [31:0] fb;
  logic               over_range;
  logic               new_bit;
  logic signed [31:0] n1;
  logic signed [31:0] n2;

  always_comb begin
    next_q = q;
    // Two-stage synchronisers for the link inputs
    next_q.clk_s1  = link.mod_clk;
    next_q.clk_s2  = q.clk_s1;
    next_q.clk_s3  = q.clk_s2;
    next_q.sync_s1 = link.sync;
    next_q.sync_s2 = q.sync_s1;
    next_q.instant = 1'b0;

    clk_rise  = q.clk_s2 & ~q.clk_s3;
    clk_fall  = ~q.clk_s2 & q.clk_s3;
    clk_edge  = clk_rise | clk_fall;
    sync_rise = 1'b0;

    level = 32'(analog_level);
    if (idle_tone_offset_enable) begin
      level = level - `SDB_IDLE_OFFSET;
      // Offset shares the headroom: clip at the shifted floor
      if (level < `SDB_IDLE_OFFSET - `SDB_FULL_SCALE) begin
        level = `SDB_IDLE_OFFSET - `SDB_FULL_SCALE;
      end
    end
    u          = loop_input(level);
    over_range = magnitude(32'(analog_level)) > `SDB_OVER_RANGE;
    fb         = q.stream_bit ? `SDB_FEEDBACK : -`SDB_FEEDBACK;
    n1         = q.int1;
    n2         = q.int2;
    new_bit    = q.stream_bit;

    // Sync level taken on the falling edge of the link clock
    if (clk_fall) begin
      next_q.sync_cap  = q.sync_s2;
      next_q.sync_prev = q.sync_cap;
      sync_rise        = q.sync_s2 & ~q.sync_cap;
    end

    // Clock-absence timer
    if (clk_edge) begin
      next_q.idle_cnt = '0;
    end else if (q.idle_cnt != 12'(PD_CYCLES)) begin
      next_q.idle_cnt = q.idle_cnt + 12'h0001;
    end

    case (q.state)
      sdb_pkg::SDB_ST_DOWN: begin
        next_q.stream_bit = 1'b0;
        next_q.flag       = 1'b0;
        if (sync_rise) begin
          next_q.state = sdb_pkg::SDB_ST_ARMED;
        end
      end
      sdb_pkg::SDB_ST_ARMED: begin
        if (clk_rise) begin
          // Sync instant: sample timing restarts here
          next_q.state    = sdb_pkg::SDB_ST_RUN;
          next_q.phase    = 2'h0;
          next_q.instant  = 1'b1;
          next_q.int1     = '0;
          next_q.int2     = '0;
          next_q.unstable = 1'b0;
          next_q.ok_cnt   = '0;
          next_q.flag     = 1'b0;
        end
      end
      sdb_pkg::SDB_ST_RUN: begin
        if (sync_rise) begin
          next_q.state = sdb_pkg::SDB_ST_ARMED;
        end else if (clk_rise) begin
          next_q.phase = q.phase + 2'h1;
          // Stability watch, counted in link clock cycles
          if (over_range) begin
            next_q.unstable = 1'b1;
            next_q.ok_cnt   = '0;
          end else if (q.unstable) begin
            if (q.ok_cnt == 6'(RECOVER - 1)) begin
              next_q.unstable = 1'b0;
              next_q.ok_cnt   = '0;
              next_q.int1     = '0;
              next_q.int2     = '0;
            end else begin
              next_q.ok_cnt = q.ok_cnt + 6'h01;
            end
          end
          next_q.flag = over_range | (q.unstable & (q.ok_cnt != 6'(RECOVER - 1)));
          // New bit on each fourth rising edge, held until the next
          if (q.phase == 2'h3) begin
            if (q.unstable | over_range) begin
              // First-order fallback loop
              n1      = q.int1 + u - fb;
              n2      = '0;
              new_bit = n1 >= 0;
            end else begin
              // Second-order loop
              n1      = q.int1 + u - fb;
              n2      = q.int2 + n1 - fb;
              new_bit = n2 >= 0;
            end
            next_q.int1       = n1;
            next_q.int2       = n2;
            next_q.stream_bit = new_bit;
          end
        end
      end
      default: begin
        next_q.state = sdb_pkg::SDB_ST_DOWN;
      end
    endcase

    // Clock gone too long: power down on its own
    if (!clk_edge && q.idle_cnt == 12'(PD_CYCLES - 1)) begin
      next_q.state      = sdb_pkg::SDB_ST_DOWN;
      next_q.stream_bit = 1'b0;
      next_q.flag       = 1'b0;
      next_q.int1       = '0;
      next_q.int2       = '0;
      next_q.unstable   = 1'b0;
      next_q.ok_cnt     = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      q.clk_s1     <= 1'b0;
      q.clk_s2     <= 1'b0;
      q.clk_s3     <= 1'b0;
      q.sync_s1    <= 1'b0;
      q.sync_s2    <= 1'b0;
      q.sync_cap   <= 1'b0;
      q.sync_prev  <= 1'b0;
      q.state      <= sdb_pkg::SDB_ST_DOWN;
      q.idle_cnt   <= 12'h000;
      q.phase      <= 2'h0;
      q.int1       <= 32'sh0000_0000;
      q.int2       <= 32'sh0000_0000;
      q.unstable   <= 1'b0;
      q.ok_cnt     <= 6'h00;
      q.stream_bit <= 1'b0;
      q.flag       <= 1'b0;
      q.instant    <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // Stream and flag out to the filter
  assign link.stream_bit           = q.stream_bit;
  assign link.overrange_error_flag = q.flag;
  assign powered_down              = (q.state == sdb_pkg::SDB_ST_DOWN);
  assign sync_instant              = q.instant;

endmodule // sdb_modulator

// [sdb_filter.sv]
// Filter end: makes the modulator clock and sync, decimates the stream.
// Assumes the stream and flag come from another chip and are synchronised here.
`include "sdb_regs.svh"

module sdb_filter #(
  parameter int HALF_CYCLES = `SDB_MOD_HALF_CYCLES,
  parameter int WINDOW      = `SDB_DECIM_BITS,
  parameter int GAIN        = `SDB_DECIM_GAIN
) (
  input  wire logic               mclk,
  input  wire logic               reset,
  sdb_link_if.filter              link,
  input  wire logic               clock_enable,
  input  wire logic               sync_request,
  input  wire logic               offset_correct_enable,
  input  wire logic               offset_capture,
  output logic signed [23:0]      result,
  output logic                    result_valid,
  output logic [12:0]             ones_count,
  output logic                    overrange_error
);

  sdb_pkg::sdb_filt_state_t q;
  sdb_pkg::sdb_filt_state_t next_q;

  // Density over a window to a signed 24-bit code
  function automatic logic signed [23:0] to_code(input logic [12:0] ones);
    logic signed [31:0] net;
    net = 2 * 32'(ones) - WINDOW;
    return 24'(net * GAIN);
  endfunction

  logic rise;
  logic fall;

  always_comb begin
    next_q              = q;
    next_q.bit_s1       = link.stream_bit;
    next_q.bit_s2       = q.bit_s1;
    next_q.flag_s1      = link.overrange_error_flag;
    next_q.flag_s2      = q.flag_s1;
    next_q.result_valid = 1'b0;
    rise                = 1'b0;
    fall                = 1'b0;

    if (sync_request) begin
      next_q.sync_pend = 1'b1;
    end
    if (offset_capture) begin
      next_q.offset = q.raw;
    end

    // Divider for the modulator clock
    if (!clock_enable) begin
      next_q.div_cnt = '0;
      next_q.mod_clk = 1'b0;
    end else if (q.div_cnt == 8'(HALF_CYCLES - 1)) begin
      next_q.div_cnt = '0;
      next_q.mod_clk = ~q.mod_clk;
      rise           = ~q.mod_clk;
      fall           = q.mod_clk;
    end else begin
      next_q.div_cnt = q.div_cnt + 8'h01;
    end

    // Sync changes on rising edges so it is steady at the falling edge
    if (rise) begin
      next_q.phase = q.phase + 2'h1;
      if (q.sync_out) begin
        next_q.sync_out = 1'b0;
        next_q.phase    = 2'h0;
        next_q.aligned  = 1'b1;
        next_q.ones     = '0;
        next_q.bits     = '0;
      end else if (q.sync_pend) begin
        next_q.sync_out  = 1'b1;
        next_q.sync_pend = sync_request;
      end
    end

    // Bit sampled on the first falling edge of phase 0, once per four modulator clocks
    if (fall && q.aligned && q.phase == 2'h0) begin
      next_q.ones = q.ones + {12'h000, q.bit_s2};
      next_q.bits = q.bits + 13'h0001;
      if (q.bits == 13'(WINDOW - 1)) begin
        next_q.ones         = '0;
        next_q.bits         = '0;
        next_q.ones_count   = q.ones + {12'h000, q.bit_s2};
        next_q.raw          = to_code(q.ones + {12'h000, q.bit_s2});
        next_q.result       = offset_correct_enable ? next_q.raw - q.offset : next_q.raw;
        next_q.result_valid = 1'b1;
      end
    end
    if (!clock_enable) begin
      next_q.aligned  = 1'b0;
      next_q.sync_out = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign link.mod_clk    = q.mod_clk;
  assign link.sync       = q.sync_out;
  assign result          = q.result;
  assign result_valid    = q.result_valid;
  assign ones_count      = q.ones_count;
  assign overrange_error = q.flag_s2;

endmodule // sdb_filter

// [sdb_link_asserts.sv]
// Checker for the modulator link: clock, sync, stream and flag timing.
// Assumes a link clock half period of 3 mclk cycles; placed beside the link.
module sdb_link_asserts #(
  parameter int PD_CYCLES = 200
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic mod_clk,
  input wire logic sync,
  input wire logic stream_bit,
  input wire logic overrange_error_flag
);
  localparam int BIT_CYC = 24;
  logic [15:0] idle;
  logic [7:0]  hold;
  logic [5:0]  rises;
  logic        dn;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Cycles since link clock edge and stream change; link clock rises since flag rise
  always_ff @(posedge mclk) begin
    if (reset) begin
      idle  <= 16'h0000;
      hold  <= 8'hFF;
      rises <= 6'h00;
      dn    <= 1'b1;
    end else begin
      idle  <= $changed(mod_clk) ? 16'h0000 : (idle == 16'hFFFF ? idle : idle + 16'h0001);
      hold  <= $changed(stream_bit) ? 8'h00 : (hold == 8'hFF ? hold : hold + 8'h01);
      if ($rose(overrange_error_flag)) begin
        rises <= 6'h00;
      end else if ($rose(mod_clk) && rises != 6'h3F) begin
        rises <= rises + 6'h01;
      end
      if ($fell(sync)) begin
        dn <= 1'b0;
      end else if (idle == 16'(PD_CYCLES + 10)) begin
        dn <= 1'b1;
      end
    end
  end

  sequence s_clk_high;
    mod_clk[*3] ##1 !mod_clk;
  endsequence

  sequence s_sync_pulse;
    sync[*6] ##1 !sync;
  endsequence

  clk_high_a: assert property ($rose(mod_clk) |-> s_clk_high) else $error("link clock high time wrong");
  sync_width_a: assert property ($rose(sync) |-> s_sync_pulse) else $error("sync pulse width wrong");
  sync_edge_a: assert property ($changed(sync) |-> mod_clk) else $error("sync moved near falling edge");
  sync_live_a: assert property ($rose(sync) |-> idle < 16'h0006) else $error("sync without clock");
  bit_hold_a: assert property ($changed(stream_bit) |-> hold >= 8'(BIT_CYC - 1))
    else $error("stream bit held too short");
  idle_quiet_a: assert property (idle >= 16'(PD_CYCLES + 10) |-> !stream_bit && !overrange_error_flag)
    else $error("outputs active after clock loss");
  wake_hold_a: assert property (dn |-> !stream_bit) else $error("stream moved before sync");
  flag_hold_a: assert property ($fell(overrange_error_flag) && idle < 16'(PD_CYCLES) |-> rises >= 6'd32)
    else $error("flag cleared too early");
endmodule // sdb_link_asserts

// [tb_top.sv]
// Testbench: both link ends joined, driven from their user sides, observed there and on the link.
// Assumes 100 MHz mclk; link clock, window and power-down counts are shortened.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 3;
  localparam int PD   = 200;
  localparam int WIN  = 512;
  localparam int GAIN = 16544;
  logic               mclk, reset, clk_en, sync_req, corr_en, cap, ofs_en;
  logic signed [23:0] level, result;
  logic               result_valid, overrange_error, powered_down, sync_instant;
  logic [12:0]        ones_count;
  int                 error_cnt, n_checks;
  logic signed [23:0] lv   [7] = '{24'h40_0000, 24'h00_0000, 24'hC0_0000, 24'hC0_0000, 24'h40_0000,
                                   24'h00_0000, 24'h00_0000};
  logic signed [23:0] code [7] = '{24'h5D_1420, 24'h00_0000, 24'hA2_EBE0, 24'hA5_27C0, 24'h5A_D840,
                                   24'hFD_C420, 24'h00_0000};
  int                 pct  [7] = '{86, 50, 14, 0, 0, 0, 0};
  logic [6:0]         ofs      = 7'h78;

  sdb_link_if sdb_link_if_i ();
  sdb_modulator #(.PD_CYCLES(PD)) sdb_modulator_i (.mclk(mclk), .reset(reset), .link(sdb_link_if_i),
    .analog_level(level), .idle_tone_offset_enable(ofs_en), .powered_down(powered_down),
    .sync_instant(sync_instant));
  sdb_filter #(.HALF_CYCLES(HALF), .WINDOW(WIN), .GAIN(GAIN)) sdb_filter_i (.mclk(mclk), .reset(reset),
    .link(sdb_link_if_i), .clock_enable(clk_en), .sync_request(sync_req), .offset_correct_enable(corr_en),
    .offset_capture(cap), .result(result), .result_valid(result_valid), .ones_count(ones_count),
    .overrange_error(overrange_error));
  sdb_link_asserts #(.PD_CYCLES(PD)) sdb_link_asserts_i (.mclk(mclk), .reset(reset),
    .mod_clk(sdb_link_if_i.mod_clk), .sync(sdb_link_if_i.sync), .stream_bit(sdb_link_if_i.stream_bit),
    .overrange_error_flag(sdb_link_if_i.overrange_error_flag));

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check_near(input string nm, input logic signed [24:0] exp, got, input int tol);
    n_checks++;
    if (((got - exp) <= tol && (exp - got) <= tol) !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  task automatic wait_for(input int which, input int lim);
    int k;
    k = 0;
    while (!((which == 0 && sync_instant === 1'b1) || (which == 1 && result_valid === 1'b1) ||
             (which == 2 && overrange_error === 1'b1) || (which == 3 && overrange_error === 1'b0) ||
             (which == 4 && powered_down === 1'b1) || (which == 5 && sdb_link_if_i.mod_clk === 1'b0))) begin
      if (k++ == lim) begin
        error_cnt++;
        $display("MISMATCH wait %0d expected 1 seen 0", which);
        give_verdict();
      end
      tick(1);
    end
  endtask

  task automatic do_sync();
    sync_req = 1'b1;
    tick(1);
    sync_req = 1'b0;
    wait_for(0, 40);
    tick(1);
    check_near("powered_down", 0, powered_down, 0);
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    reset = 1'b1;
    clk_en = 1'b0;
    sync_req = 1'b0;
    corr_en = 1'b0;
    cap = 1'b0;
    ofs_en = 1'b0;
    level = lv[0];
    error_cnt = 0;
    n_checks = 0;
    tick(2);
    reset = 1'b0;
    check_near("powered_down", 1, powered_down, 0);
    check_near("stream_bit", 0, sdb_link_if_i.stream_bit, 0);
    clk_en = 1'b1;
    tick(20);
    do_sync();
    $display("test sync done");
    for (int i = 0; i < 7; i++) begin
      wait_for(1, WIN * 8 * HALF + 100);
      check_near("result", code[i], result, 81920);
      if (pct[i] != 0) check_near("ones_count", WIN * pct[i] / 100, {12'h000, ones_count}, 6);
      if (i < 6) begin
        level = lv[i + 1];
        ofs_en = ofs[i + 1];
        cap = (i == 5);
        corr_en = (i == 5);
        tick(1);
        cap = 1'b0;
      end
    end
    $display("test codes done");
    level = 24'h44_0000;
    ofs_en = 1'b0;
    corr_en = 1'b0;
    wait_for(2, 100);
    level = 24'h00_0000;
    tick(26 * 2 * HALF);
    check_near("overrange_error", 1, overrange_error, 0);
    wait_for(3, 12 * 2 * HALF);
    $display("test overrange done");
    wait_for(5, 20);
    clk_en = 1'b0;
    tick(PD - 20);
    check_near("powered_down", 0, powered_down, 0);
    wait_for(4, 40);
    check_near("stream_bit", 0, sdb_link_if_i.stream_bit, 0);
    tick(20);
    check_near("stream_bit", 0, sdb_link_if_i.stream_bit, 0);
    clk_en = 1'b1;
    tick(100);
    check_near("powered_down", 1, powered_down, 0);
    check_near("stream_bit", 0, sdb_link_if_i.stream_bit, 0);
    do_sync();
    $display("test power down done");
    give_verdict();
  end
endmodule // tb_top
